// File: shared/adfm_map.svh
// register offsets, field positions, limits and timing counts of the fault monitor
`ifndef ADFM_MAP_SVH
`define ADFM_MAP_SVH
`define ADFM_OFF_ENABLE     12'h000
`define ADFM_OFF_FAULT      12'h004
`define ADFM_OFF_STATUS     12'h008
`define ADFM_OFF_CLKCNT     12'h00C
`define ADFM_OFF_CTRL       12'h010
`define ADFM_OFF_OFFSET     12'h014
`define ADFM_OFF_GAIN       12'h018
`define ADFM_OFF_DATA       12'h01C
`define ADFM_EN_RESET       32'h0000_0000
`define ADFM_OFFSET_RESET   24'h80_0000
`define ADFM_GAIN_RESET     24'h50_0000
`define ADFM_OFFSET_HI      24'h7F_FFFF
`define ADFM_OFFSET_LO      24'hF8_0000
`define ADFM_DATA_ONES      24'hFF_FFFF
`define ADFM_DATA_ZEROS     24'h00_0000
`define ADFM_SAT_RUN        5'h14
`define ADFM_CLK_DIV        8'h83
`define ADFM_CLKCNT_W       16
// channel select field in the control register and the test source code
`define ADFM_CH_LSB         0
`define ADFM_CH_TEST_SRC    4'hF
`endif

// File: shared/adfm_pkg.sv
// types of the fault monitor
`include "adfm_map.svh"
package adfm_pkg;
    typedef struct packed {
        logic       clock_monitor_enable;
        logic       decap_check_selftest;
        logic [1:0] decap_check_select;
        logic       digital_reg_trip_test;
        logic       analog_reg_trip_test;
        logic       digital_reg_monitor_enable;
        logic       analog_reg_monitor_enable;
        logic       neg_under_enable;
        logic       neg_over_enable;
        logic       pos_under_enable;
        logic       pos_over_enable;
        logic       sat_fault_enable;
        logic       conv_fault_enable;
        logic       cal_fault_enable;
        logic       ref_missing_enable;
    } adfm_en_t;

    typedef struct packed {
        logic decap_fault_flag;
        logic digital_reg_fault_flag;
        logic analog_reg_fault_flag;
        logic neg_under_flag;
        logic neg_over_flag;
        logic pos_under_flag;
        logic pos_over_flag;
        logic sat_fault_flag;
        logic conv_fault_flag;
        logic cal_fault_flag;
        logic ref_missing_flag;
    } adfm_flags_t;

    // analog comparator levels, asynchronous, synchronised by two flip-flops inside the monitor
    typedef struct packed {
        logic ref_low;
        logic pos_over;
        logic pos_under;
        logic neg_over;
        logic neg_under;
        logic analog_reg_low;
        logic digital_reg_low;
        logic decap_droop;
    } adfm_cmp_t;

    // one filter result with its overflow indications
    typedef struct packed {
        logic        valid;
        logic [23:0] value;
        logic        overflow;
        logic        underflow;
    } adfm_result_t;

    typedef enum logic [1:0] {
        ADFM_CAL_NONE,
        ADFM_CAL_OFFSET,
        ADFM_CAL_GAIN
    } adfm_cal_t;

    typedef struct packed {
        adfm_en_t                  en;
        adfm_flags_t               flags;
        logic [3:0]                chan;
        logic [23:0]               offset;
        logic [23:0]               gain;
        logic [23:0]               data;
        logic [7:0]                div;
        logic [`ADFM_CLKCNT_W-1:0] clkcnt;
        logic [4:0]                run;
        logic                      last_bit;
        logic [31:0]               prdata;
        logic [7:0]                sync1;
        logic [7:0]                sync2;
        logic                      mod_s1;
        logic                      mod_s2;
    } adfm_state_t;
endpackage : adfm_pkg

// File: src/adfm_monitor.sv
// diagnostic fault monitor of the sigma-delta converter, APB register slave
`timescale 1ns/1ps
`include "adfm_map.svh"
module adfm_monitor
    import adfm_pkg::*;
(
    input  wire logic                      i_clk,
    input  wire logic                      i_rst_n,
    input  wire logic                      i_psel,
    input  wire logic                      i_penable,
    input  wire logic                      i_pwrite,
    input  wire logic [11:0]               i_paddr,
    input  wire logic [31:0]               i_pwdata,
    output logic      [31:0]               o_prdata,
    output logic                           o_pready,
    output logic                           o_pslverr,
    input  wire adfm_cmp_t                 i_cmp,
    input  wire logic                      i_mod_bit,
    input  wire adfm_result_t              i_result,
    input  wire adfm_cal_t                 i_cal_mode,
    input  wire logic                      i_cal_done,
    input  wire logic [23:0]               i_cal_coef,
    output logic      [23:0]               o_data,
    output logic      [23:0]               o_offset,
    output logic      [23:0]               o_gain,
    output logic      [`ADFM_CLKCNT_W-1:0] o_clk_count,
    output logic                           o_summary_fault,
    output logic                           o_test_source_sel,
    output logic                           o_analog_reg_trip,
    output logic                           o_digital_reg_trip,
    output logic                           o_analog_regulator_off,
    output logic                           o_digital_regulator_off,
    output logic                           o_decap_disconnect
);
    adfm_state_t q, d;
    adfm_cmp_t   cmp;
    adfm_flags_t set_v;
    logic        wr, rd, hit, fault_rd, sat_now;

    // offset window wraps through zero: at or above the low bound or at or below the high bound
    function automatic logic offset_ok(input logic [23:0] c);
        offset_ok = (c <= `ADFM_OFFSET_HI) || (c >= `ADFM_OFFSET_LO);
    endfunction : offset_ok

    function automatic logic addr_hit(input logic [11:0] a);
        addr_hit = (a == `ADFM_OFF_ENABLE) || (a == `ADFM_OFF_FAULT)  ||
                   (a == `ADFM_OFF_STATUS) || (a == `ADFM_OFF_CLKCNT) ||
                   (a == `ADFM_OFF_CTRL)   || (a == `ADFM_OFF_OFFSET) ||
                   (a == `ADFM_OFF_GAIN)   || (a == `ADFM_OFF_DATA);
    endfunction : addr_hit

    assign cmp = adfm_cmp_t'(q.sync2);

    always_comb begin
        d        = q;
        wr       = i_psel && i_penable && i_pwrite;
        rd       = i_psel && i_penable && !i_pwrite;
        hit      = addr_hit(i_paddr);
        fault_rd = rd && (i_paddr == `ADFM_OFF_FAULT);
        sat_now  = 1'b0;
        set_v    = '0;

        // comparators arrive from analog, two flip-flops before use
        d.sync1  = i_cmp;
        d.sync2  = q.sync1;
        d.mod_s1 = i_mod_bit;
        d.mod_s2 = q.mod_s1;

        // saturation run length of identical modulator bits
        if (q.mod_s2 == q.last_bit) begin
            if (q.run != `ADFM_SAT_RUN) begin
                d.run = q.run + 5'h01;
            end
        end else begin
            d.run = 5'h01;
        end
        d.last_bit = q.mod_s2;
        sat_now    = (q.run == `ADFM_SAT_RUN);

        set_v.ref_missing_flag = q.en.ref_missing_enable && cmp.ref_low;
        set_v.sat_fault_flag   = q.en.sat_fault_enable && sat_now;
        set_v.pos_over_flag    = q.en.pos_over_enable && cmp.pos_over;
        set_v.pos_under_flag   = q.en.pos_under_enable && cmp.pos_under;
        set_v.neg_over_flag    = q.en.neg_over_enable && cmp.neg_over;
        set_v.neg_under_flag   = q.en.neg_under_enable && cmp.neg_under;
        // trip test feeds ground, which the monitor sees as low regulator
        set_v.analog_reg_fault_flag  = q.en.analog_reg_monitor_enable &&
            (cmp.analog_reg_low || q.en.analog_reg_trip_test);
        set_v.digital_reg_fault_flag = q.en.digital_reg_monitor_enable &&
            (cmp.digital_reg_low || q.en.digital_reg_trip_test);
        set_v.decap_fault_flag = (q.en.decap_check_select != 2'b00) &&
            (cmp.decap_droop || q.en.decap_check_selftest);

        // conversion result: ref fault wins, then filter clamps
        if (i_result.valid && i_cal_mode == ADFM_CAL_NONE) begin
            if (set_v.ref_missing_flag || q.flags.ref_missing_flag) begin
                d.data = `ADFM_DATA_ONES;
            end else if (i_result.overflow) begin
                d.data = `ADFM_DATA_ONES;
            end else if (i_result.underflow) begin
                d.data = `ADFM_DATA_ZEROS;
            end else begin
                d.data = i_result.value;
            end
            set_v.conv_fault_flag = q.en.conv_fault_enable &&
                (i_result.overflow || i_result.underflow);
        end

        // coefficient load at calibration end
        if (i_cal_done) begin
            if (set_v.ref_missing_flag || q.flags.ref_missing_flag) begin
                set_v.ref_missing_flag = q.en.ref_missing_enable;
            end else if (i_cal_mode == ADFM_CAL_OFFSET) begin
                if (offset_ok(i_cal_coef)) begin
                    d.offset = i_cal_coef;
                end else begin
                    set_v.cal_fault_flag = q.en.cal_fault_enable;
                end
            end else if (i_cal_mode == ADFM_CAL_GAIN) begin
                if (i_result.overflow) begin
                    set_v.cal_fault_flag = q.en.cal_fault_enable;
                end else begin
                    d.gain = i_cal_coef;
                end
            end
        end

        // read clears, set in the same cycle wins so no event is lost
        if (fault_rd) begin
            d.flags = set_v;
        end else begin
            d.flags = q.flags | set_v;
        end

        // master clock monitor, width set by the count parameter
        if (q.en.clock_monitor_enable) begin
            if (q.div == `ADFM_CLK_DIV - 8'h01) begin
                d.div    = 8'h00;
                d.clkcnt = q.clkcnt + 1'b1;
            end else begin
                d.div = q.div + 8'h01;
            end
        end else begin
            d.div = 8'h00;
        end

        if (wr) begin
            case (i_paddr)
                `ADFM_OFF_ENABLE: d.en   = adfm_en_t'(i_pwdata[$bits(adfm_en_t)-1:0]);
                `ADFM_OFF_CTRL:   d.chan = i_pwdata[`ADFM_CH_LSB +: 4];
                default:          d.en   = d.en;
            endcase
        end

        d.prdata = 32'h0000_0000;
        if (i_psel && !i_penable && !i_pwrite) begin
            case (i_paddr)
                `ADFM_OFF_ENABLE: d.prdata = 32'(q.en);
                // flags as they stand after this edge, so the clearing read shows every event
                `ADFM_OFF_FAULT:  d.prdata = 32'(q.flags | set_v);
                `ADFM_OFF_STATUS: d.prdata = 32'((q.flags | set_v) != '0);
                `ADFM_OFF_CLKCNT: d.prdata = 32'(q.clkcnt);
                `ADFM_OFF_CTRL:   d.prdata = 32'(q.chan);
                `ADFM_OFF_OFFSET: d.prdata = 32'(q.offset);
                `ADFM_OFF_GAIN:   d.prdata = 32'(q.gain);
                `ADFM_OFF_DATA:   d.prdata = 32'(q.data);
                default:          d.prdata = 32'h0000_0000;
            endcase
        end else if (i_psel && i_penable) begin
            d.prdata = q.prdata;
        end

        if (!i_rst_n) begin
            d        = '0;
            d.en     = adfm_en_t'(`ADFM_EN_RESET);
            d.offset = `ADFM_OFFSET_RESET;
            d.gain   = `ADFM_GAIN_RESET;
        end
    end

    always_ff @(posedge i_clk) begin
        q <= d;
    end

    // access phase completes in one cycle; read data captured in setup
    assign o_pready  = 1'b1;
    assign o_pslverr = i_psel && i_penable && !hit;
    assign o_prdata  = q.prdata;

    assign o_data          = q.data;
    assign o_offset        = q.offset;
    assign o_gain          = q.gain;
    assign o_clk_count     = q.clkcnt;
    assign o_summary_fault = (q.flags != '0);
    assign o_test_source_sel  = (q.chan == `ADFM_CH_TEST_SRC);
    assign o_analog_reg_trip  = q.en.analog_reg_trip_test;
    assign o_digital_reg_trip = q.en.digital_reg_trip_test;
    // both bits set is host misuse; analog wins so only one regulator drops
    assign o_analog_regulator_off  = q.en.decap_check_select[0];
    assign o_digital_regulator_off = q.en.decap_check_select[1] &&
                                     !q.en.decap_check_select[0];
    assign o_decap_disconnect = q.en.decap_check_selftest;
endmodule : adfm_monitor

// File: sim/adfm_afe_model.sv
// analog front end model: comparator levels seen by the fault monitor
`timescale 1ns/1ps
module adfm_afe_model
    import adfm_pkg::*;
(
    input  wire adfm_cmp_t i_level,
    input  wire logic      i_analog_reg_trip,
    input  wire logic      i_digital_reg_trip,
    input  wire logic      i_analog_regulator_off,
    input  wire logic      i_digital_regulator_off,
    input  wire logic      i_decap_disconnect,
    output adfm_cmp_t      o_cmp
);
    always_comb begin
        o_cmp = i_level;
        // a grounded monitor input always reads as an undervoltage
        o_cmp.analog_reg_low  = i_level.analog_reg_low | i_analog_reg_trip;
        o_cmp.digital_reg_low = i_level.digital_reg_low | i_digital_reg_trip;
        // without its capacitor a switched-off regulator droops at once
        o_cmp.decap_droop = i_level.decap_droop | (i_decap_disconnect
            & (i_analog_regulator_off | i_digital_regulator_off));
    end
endmodule : adfm_afe_model

// File: sim/adfm_props.sv
// port assertions of the fault monitor
`timescale 1ns/1ps
`include "adfm_map.svh"
module adfm_props
    import adfm_pkg::*;
(
    input wire logic                      i_clk,
    input wire logic                      i_rst_n,
    input wire logic                      i_psel,
    input wire logic                      i_penable,
    input wire logic                      i_pwrite,
    input wire logic [11:0]               i_paddr,
    input wire logic [31:0]               i_pwdata,
    input wire adfm_result_t              i_result,
    input wire adfm_cal_t                 i_cal_mode,
    input wire logic                      i_cal_done,
    input wire logic [23:0]               i_cal_coef,
    input wire logic [23:0]               o_data,
    input wire logic [23:0]               o_offset,
    input wire logic [23:0]               o_gain,
    input wire logic [`ADFM_CLKCNT_W-1:0] o_clk_count,
    input wire logic                      o_test_source_sel,
    input wire logic                      o_analog_reg_trip,
    input wire logic                      o_analog_regulator_off,
    input wire logic                      o_decap_disconnect
);
    // shadow of the enable and control registers, rebuilt from bus writes
    logic [15:0] en_q;
    logic [3:0]  ch_q;
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            en_q <= 16'h0000;
            ch_q <= 4'h0;
        end else if (i_psel && i_penable && i_pwrite) begin
            if (i_paddr == `ADFM_OFF_ENABLE) en_q <= i_pwdata[15:0];
            if (i_paddr == `ADFM_OFF_CTRL) ch_q <= i_pwdata[3:0];
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    property p_trip; o_analog_reg_trip == en_q[10]; endproperty
    a_trip: assert property (p_trip) else $error("trip test output wrong");
    property p_off_reg; o_analog_regulator_off == en_q[12]; endproperty
    a_off_reg: assert property (p_off_reg) else $error("regulator off wrong");
    property p_disc; en_q[14] |-> o_decap_disconnect; endproperty
    a_disc: assert property (p_disc) else $error("capacitor not disconnected");
    property p_tsrc; o_test_source_sel == (ch_q == `ADFM_CH_TEST_SRC); endproperty
    a_tsrc: assert property (p_tsrc) else $error("test source select wrong");
    property p_offwin; i_cal_done && i_cal_mode == ADFM_CAL_OFFSET
        && i_cal_coef inside {[24'h800000:24'hF7FFFF]} |=> $stable(o_offset); endproperty
    a_offwin: assert property (p_offwin) else $error("offset written outside window");
    property p_gainovf; i_cal_done && i_cal_mode == ADFM_CAL_GAIN && i_result.overflow
        |=> $stable(o_gain); endproperty
    a_gainovf: assert property (p_gainovf) else $error("gain written on overflow");
    property p_clamp; i_result.valid && (i_result.overflow || i_result.underflow)
        |=> o_data inside {`ADFM_DATA_ZEROS, `ADFM_DATA_ONES}; endproperty
    a_clamp: assert property (p_clamp) else $error("result not clamped");
    property p_step; $changed(o_clk_count) |-> o_clk_count == $past(o_clk_count) + 1'b1;
    endproperty
    a_step: assert property (p_step) else $error("clock count step wrong");
    property p_hold; !en_q[15] |=> $stable(o_clk_count); endproperty
    a_hold: assert property (p_hold) else $error("clock count moved while off");
endmodule : adfm_props
bind adfm_monitor adfm_props adfm_props_i (
    .i_clk, .i_rst_n, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .i_result,
    .i_cal_mode, .i_cal_done, .i_cal_coef, .o_data, .o_offset, .o_gain, .o_clk_count,
    .o_test_source_sel, .o_analog_reg_trip, .o_analog_regulator_off, .o_decap_disconnect
);

// File: sim/tb.sv
// self-checking bench of the fault monitor
`timescale 1ns/1ps
`include "adfm_map.svh"
`define CHK(a, e) begin \
    comparisons++; \
    if ((a) !== (e)) begin \
        failures++; \
        $display("Error at %0t: got %h expected %h", $time, a, e); \
    end \
end
module tb
    import adfm_pkg::*;
;
    localparam logic [11:0] en_a = `ADFM_OFF_ENABLE;
    localparam logic [11:0] ft_a = `ADFM_OFF_FAULT;
    localparam logic [23:0] g0   = `ADFM_GAIN_RESET;
    logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, err, cal_done, mod_bit;
    logic        hold, tsel, atrip, dtrip, aoff, doff, disc, summary;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [23:0] cal_coef, data, offset, gain;
    logic [`ADFM_CLKCNT_W-1:0] clk_count, c;
    adfm_cmp_t    level, cmp;
    adfm_result_t result;
    adfm_cal_t    cal_mode;
    int           failures, comparisons, cycles, n;
    adfm_monitor adfm_monitor_i (
        .i_clk(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_cmp(cmp), .i_mod_bit(mod_bit),
        .i_result(result), .i_cal_mode(cal_mode), .i_cal_done(cal_done),
        .i_cal_coef(cal_coef), .o_data(data), .o_offset(offset), .o_gain(gain),
        .o_clk_count(clk_count), .o_summary_fault(summary), .o_test_source_sel(tsel),
        .o_analog_reg_trip(atrip), .o_digital_reg_trip(dtrip),
        .o_analog_regulator_off(aoff), .o_digital_regulator_off(doff),
        .o_decap_disconnect(disc));
    adfm_afe_model adfm_afe_model_i (
        .i_level(level), .i_analog_reg_trip(atrip), .i_digital_reg_trip(dtrip),
        .i_analog_regulator_off(aoff), .i_digital_regulator_off(doff),
        .i_decap_disconnect(disc), .o_cmp(cmp));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // toggling keeps the modulator out of saturation unless a scenario holds it
    always @(posedge clk) begin
        if (!hold) mod_bit <= ~mod_bit;
        cycles++;
        if (cycles == 20000) begin
            failures++;
            stop_test();
        end
    end
    task automatic stop_test();
        $display("TB: %0d failures, %0d comparisons", failures, comparisons);
        if (failures == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : stop_test
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
    endtask : tick
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        q = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(q, e)
    endtask : rd
    task automatic res(input logic o, input logic u, input logic [23:0] v);
        result <= '{1'b1, v, o, u};
        @(posedge clk);
        result <= '0;
        @(posedge clk);
    endtask : res
    task automatic cal(input adfm_cal_t m, input logic [23:0] k, input logic o,
                       input logic [23:0] eo, input logic [23:0] eg);
        cal_mode <= m;
        cal_done <= 1'b1;
        cal_coef <= k;
        result   <= '{1'b0, 24'h0, o, 1'b0};
        @(posedge clk);
        cal_mode <= ADFM_CAL_NONE;
        cal_done <= 1'b0;
        result   <= '0;
        @(posedge clk);
        `CHK(offset, eo)
        `CHK(gain, eg)
    endtask : cal
    initial begin
        rst_n <= 1'b0;
        {psel, penable, pwrite, paddr, pwdata, mod_bit, hold, cal_done, cal_coef} <= '0;
        level <= '0;
        result <= '0;
        cal_mode <= ADFM_CAL_NONE;
        tick(10);
        rst_n <= 1'b1;
        @(posedge clk);
        rd(`ADFM_OFF_OFFSET, {8'h00, `ADFM_OFFSET_RESET});
        rd(`ADFM_OFF_GAIN, {8'h00, g0});
        rd(12'h020, 32'h0);
        `CHK(err, 1'b1)
        level <= 8'hFF;
        res(1'b1, 1'b0, 24'h000001);
        cal(ADFM_CAL_OFFSET, 24'h800000, 1'b0, `ADFM_OFFSET_RESET, g0);
        rd(ft_a, 32'h0);
        level <= '0;
        tick(5);
        wr_en(32'h1);
        level.ref_low <= 1'b1;
        tick(5);
        rd(`ADFM_OFF_STATUS, 32'h1);
        `CHK(summary, 1'b1)
        res(1'b0, 1'b0, 24'h123456);
        `CHK(data, `ADFM_DATA_ONES)
        cal(ADFM_CAL_OFFSET, 24'h000010, 1'b0, `ADFM_OFFSET_RESET, g0);
        cal(ADFM_CAL_GAIN, 24'h400000, 1'b0, `ADFM_OFFSET_RESET, g0);
        rd(ft_a, 32'h1);
        rd(ft_a, 32'h1);
        level.ref_low <= 1'b0;
        tick(5);
        rd(ft_a, 32'h1);
        rd(ft_a, 32'h0);
        wr_en(32'h2);
        cal(ADFM_CAL_OFFSET, 24'hF80000, 1'b0, 24'hF80000, g0);
        cal(ADFM_CAL_OFFSET, 24'h800000, 1'b0, 24'hF80000, g0);
        cal(ADFM_CAL_OFFSET, 24'hF7FFFF, 1'b0, 24'hF80000, g0);
        cal(ADFM_CAL_OFFSET, 24'h7FFFFF, 1'b0, 24'h7FFFFF, g0);
        cal(ADFM_CAL_GAIN, 24'h123456, 1'b1, 24'h7FFFFF, g0);
        cal(ADFM_CAL_GAIN, 24'h654321, 1'b0, 24'h7FFFFF, 24'h654321);
        rd(ft_a, 32'h2);
        wr_en(32'h4);
        res(1'b0, 1'b1, 24'h000100);
        `CHK(data, `ADFM_DATA_ZEROS)
        res(1'b0, 1'b0, 24'h000100);
        `CHK(data, 24'h000100)
        rd(ft_a, 32'h4);
        rd(ft_a, 32'h0);
        wr_en(32'h8);
        hold <= 1'b1;
        tick(16);
        hold <= 1'b0;
        tick(4);
        rd(ft_a, 32'h0);
        hold <= 1'b1;
        tick(24);
        hold <= 1'b0;
        tick(4);
        rd(ft_a, 32'h8);
        level <= 8'h78;
        for (int k = 0; k < 4; k++) begin
            wr_en(32'h10 << k);
            rd(ft_a, (k == 0) ? 32'h10 : (32'h18 << k));
            rd(ft_a, 32'h10 << k);
        end
        level <= '0;
        tick(5);
        rd(ft_a, 32'h80);
        for (int j = 0; j < 2; j++) begin
            wr_en(32'h500 << j);
            tick(5);
            rd(ft_a, 32'h100 << j);
            wr_en(32'h100 << j);
            tick(5);
            rd(ft_a, 32'h100 << j);
            rd(ft_a, 32'h0);
        end
        wr_en(32'h2000);
        tick(5);
        `CHK({aoff, doff}, 2'b01)
        rd(ft_a, 32'h0);
        wr_en(32'h5000);
        tick(5);
        rd(ft_a, 32'h400);
        `CHK(disc, 1'b1)
        wr_en(32'h8000);
        c = clk_count;
        @(negedge clk);
        while (clk_count === c) @(negedge clk);
        c = clk_count;
        n = 0;
        while (clk_count === c && n < 300) begin
            n++;
            @(negedge clk);
        end
        `CHK(n, 131)
        `CHK(clk_count, c + 1'b1)
        @(posedge clk);
        apb(1'b1, `ADFM_OFF_CTRL, {28'h0, `ADFM_CH_TEST_SRC});
        `CHK(tsel, 1'b1)
        apb(1'b1, `ADFM_OFF_CTRL, 32'h3);
        `CHK(tsel, 1'b0)
        stop_test();
    end
    task automatic wr_en(input logic [31:0] d);
        apb(1'b1, en_a, d);
    endtask : wr_en
endmodule : tb
